// *** src/alu_branch_pkg.sv ***
// Opcodes, cycle counts and reset values for the byte core execute unit.
// Assumes an 8-bit opcode with up to two operand bytes in program order.
package alu_branch_pkg;
    // Single opcodes
    localparam logic [7:0] OP_NOTHING = 8'h00;
    localparam logic [7:0] OP_MUL = 8'h01;
    localparam logic [7:0] OP_ROT_LEFT = 8'h02;
    localparam logic [7:0] OP_ROT_RIGHT = 8'h03;
    localparam logic [7:0] OP_DIVIDE = 8'h11;
    localparam logic [7:0] OP_SUB_EXIT = 8'h20;
    localparam logic [7:0] OP_JUMP_ABS = 8'h21;
    localparam logic [7:0] OP_IRQ_EXIT = 8'h30;
    localparam logic [7:0] OP_CALL_ABS = 8'h31;
    localparam logic [7:0] OP_PUSH_ACC = 8'h40;
    localparam logic [7:0] OP_PUSH_IDX = 8'h41;
    localparam logic [7:0] OP_POP_ACC = 8'h50;
    localparam logic [7:0] OP_POP_IDX = 8'h51;
    localparam logic [7:0] OP_IRQ_OFF = 8'h80;
    localparam logic [7:0] OP_CARRY_OFF = 8'h81;
    localparam logic [7:0] OP_FIX_ADD = 8'h84;
    localparam logic [7:0] OP_IRQ_ON = 8'h90;
    localparam logic [7:0] OP_CARRY_ON = 8'h91;
    localparam logic [7:0] OP_FIX_SUB = 8'h94;
    localparam logic [7:0] OP_CMP_DIRI = 8'h95;
    localparam logic [7:0] OP_CMP_IDXI = 8'h96;
    localparam logic [7:0] OP_UP_ACC = 8'hc0;
    localparam logic [7:0] OP_UP_STK = 8'hc1;
    localparam logic [7:0] OP_UP_IDX = 8'hc2;
    localparam logic [7:0] OP_UP_XPT = 8'hc3;
    localparam logic [7:0] OP_DN_ACC = 8'hd0;
    localparam logic [7:0] OP_DN_STK = 8'hd1;
    localparam logic [7:0] OP_DN_IDX = 8'hd2;
    localparam logic [7:0] OP_DN_XPT = 8'hd3;
    localparam logic [7:0] OP_JUMP_ACC = 8'he0;
    localparam logic [7:0] OP_SWAP_PGM = 8'hf4;
    // Cycle counts
    localparam logic [4:0] CYC_ONE = 5'h01;
    localparam logic [4:0] CYC_TWO = 5'h02;
    localparam logic [4:0] CYC_THREE = 5'h03;
    localparam logic [4:0] CYC_FOUR = 5'h04;
    localparam logic [4:0] CYC_FIVE = 5'h05;
    localparam logic [4:0] CYC_SIX = 5'h06;
    localparam logic [4:0] CYC_MUL = 5'h13;
    localparam logic [4:0] CYC_DIV = 5'h15;
    // Reset values and stack step
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] STK_STEP = 16'h0002;
    localparam logic [15:0] STK_STEP_IRQ = 16'h0004;
endpackage

// *** src/cpu_alu_branch_decoder.sv ***
// Execute unit for arithmetic, logic, compare, rotate, branch, call,
// stack and flag opcodes of a small byte core.
// Assumes a fetch unit that presents an opcode with its operand bytes and
// any memory byte, popped word or vector target it needs, then waits for
// instr_ready_r before offering the next one.
`timescale 1ns/100ps
module cpu_alu_branch_decoder (
    // Clock, reset and clock enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Instruction from fetch
    input wire logic instr_valid,
    input wire logic [7:0] instr_op,
    input wire logic [7:0] instr_b1,
    input wire logic [7:0] instr_b2,
    // Data read on behalf of the instruction
    input wire logic [7:0] opnd_byte,
    input wire logic [15:0] pop_word,
    input wire logic [3:0] pop_flags,
    input wire logic [15:0] vec_target,
    // Handshake and stack write
    output logic instr_ready_r,
    output logic push_valid_r,
    output logic [15:0] push_data_r,
    // Architectural state
    output logic [15:0] program_counter_r,
    output logic [15:0] acc_r,
    output logic [15:0] tmp_r,
    output logic [15:0] index_pointer_r,
    output logic [15:0] extra_pointer_r,
    output logic [15:0] stack_top_pointer_r,
    output logic neg_r,
    output logic zero_r,
    output logic ovf_r,
    output logic carry_r,
    output logic irq_en_r
);
    logic [7:0] bank_r [8];
    logic [4:0] wait_r;
    logic take;
    logic [7:0] op, src8, x8, y8, bank_nxt;
    logic [2:0] ri;
    logic [9:0] r8;
    logic [17:0] r16;
    logic [15:0] pcn, acc_nxt, tmp_nxt, idx_nxt, xpt_nxt, stk_nxt, pgm_nxt;
    logic [15:0] x16, y16, push_d;
    logic n_nxt, z_nxt, v_nxt, c_nxt, ie_nxt, bank_we, push_nxt, bit_v;
    logic f_sel;

    // Byte add or subtract, result {carry, overflow, sum}
    function automatic logic [9:0] add8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic ci, input logic sub);
        logic [7:0] bb;
        logic [8:0] s;
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, ci ^ sub};
        return {s[8] ^ sub, (a[7] == bb[7]) && (s[7] != a[7]), s[7:0]};
    endfunction

    // Word add or subtract, result {carry, overflow, sum}
    function automatic logic [17:0] add16(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic ci, input logic sub);
        logic [15:0] bb;
        logic [16:0] s;
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {16'h0000, ci ^ sub};
        return {s[16] ^ sub, (a[15] == bb[15]) && (s[15] != a[15]),
                s[15:0]};
    endfunction

    // Logic select: 01 xor, 10 and, 11 or
    function automatic logic [15:0] lop(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic [1:0] sel);
        case (sel)
            2'b01: return a ^ b;
            2'b10: return a & b;
            default: return a | b;
        endcase
    endfunction

    // Instruction length in bytes
    function automatic logic [1:0] len_of(input logic [7:0] o);
        casez (o)
            alu_branch_pkg::OP_CMP_DIRI, alu_branch_pkg::OP_CMP_IDXI,
            alu_branch_pkg::OP_JUMP_ABS, alu_branch_pkg::OP_CALL_ABS,
            8'hb?: return 2'd3;
            8'h97, 8'b1001_1???, 8'b1111_1???: return 2'd2;
            8'b0???01??: return (o[1:0] == 2'b11) ? 2'd1 : 2'd2;
            default: return 2'd1;
        endcase
    endfunction

    // Execution time in cycles
    function automatic logic [4:0] cyc_of(input logic [7:0] o);
        casez (o)
            alu_branch_pkg::OP_MUL: return alu_branch_pkg::CYC_MUL;
            alu_branch_pkg::OP_DIVIDE: return alu_branch_pkg::CYC_DIV;
            8'h20, 8'h40, 8'h41, 8'h50, 8'h51, 8'h97, 8'b1001_1???,
            8'b1100_1???, 8'b1101_1???: return alu_branch_pkg::CYC_FOUR;
            8'h30, 8'h31, 8'b1110_1???: return alu_branch_pkg::CYC_SIX;
            8'h95, 8'h96, 8'hb?: return alu_branch_pkg::CYC_FIVE;
            8'h02, 8'h03, 8'h12, 8'h22, 8'h32, 8'h52, 8'h62, 8'h72,
            8'h84, 8'h94, 8'he0: return alu_branch_pkg::CYC_TWO;
            8'h13, 8'h23, 8'h33, 8'h53, 8'h63, 8'h73, 8'b110?00??,
            8'hf4, 8'h21, 8'b1111_1???: return alu_branch_pkg::CYC_THREE;
            // Only the idle opcode is single cycle below row 8
            8'h00, 8'b1???????: return alu_branch_pkg::CYC_ONE;
            8'b0???0100: return alu_branch_pkg::CYC_TWO;
            8'b0???0110: return alu_branch_pkg::CYC_FOUR;
            default: return alu_branch_pkg::CYC_THREE;
        endcase
    endfunction

    assign take = ce && instr_valid && instr_ready_r;
    assign op = instr_op;
    assign ri = instr_op[2:0];
    assign pcn = program_counter_r + {14'h0000, len_of(instr_op)};

    // Byte operand: immediate, memory, bank register or scratch low byte
    always_comb begin
        case (op[3:0])
            4'h2: src8 = tmp_r[7:0];
            4'h4: src8 = instr_b1;
            4'h5, 4'h6, 4'h7: src8 = opnd_byte;
            default: src8 = bank_r[ri];
        endcase
    end

    // Next state of every register for the offered opcode
    always_comb begin
        acc_nxt = acc_r;
        tmp_nxt = tmp_r;
        idx_nxt = index_pointer_r;
        xpt_nxt = extra_pointer_r;
        stk_nxt = stack_top_pointer_r;
        pgm_nxt = pcn;
        n_nxt = neg_r;
        z_nxt = zero_r;
        v_nxt = ovf_r;
        c_nxt = carry_r;
        ie_nxt = irq_en_r;
        bank_we = 1'b0;
        bank_nxt = bank_r[ri];
        push_nxt = 1'b0;
        push_d = pcn;
        x8 = acc_r[7:0];
        y8 = src8;
        x16 = acc_r;
        y16 = tmp_r;
        r8 = 10'h000;
        r16 = 18'h00000;
        bit_v = opnd_byte[ri];
        f_sel = 1'b0;
        casez (op)
            alu_branch_pkg::OP_NOTHING: ;
            alu_branch_pkg::OP_MUL:
                acc_nxt = {8'h00, acc_r[7:0]} * {8'h00, tmp_r[7:0]};
            alu_branch_pkg::OP_DIVIDE: begin
                // Zero divisor leaves both words untouched
                if (acc_r[7:0] != 8'h00) begin
                    acc_nxt = tmp_r / {8'h00, acc_r[7:0]};
                    acc_nxt[15:8] = 8'h00; // Quotient high byte cleared
                    tmp_nxt = tmp_r % {8'h00, acc_r[7:0]};
                end
            end
            alu_branch_pkg::OP_ROT_LEFT, alu_branch_pkg::OP_ROT_RIGHT: begin
                x8 = op[0] ? {carry_r, acc_r[7:1]}
                           : {acc_r[6:0], carry_r};
                c_nxt = op[0] ? acc_r[0] : acc_r[7];
                acc_nxt = {acc_r[15:8], x8};
                n_nxt = x8[7];
                z_nxt = (x8 == 8'h00);
            end
            8'h13, 8'h23, 8'h33: begin
                x16 = op[4] ? tmp_r : acc_r;
                y16 = op[4] ? acc_r : tmp_r;
                r16 = add16(x16, y16, op[5] & carry_r, op[4]);
                if (op[5]) acc_nxt = r16[15:0];
                {c_nxt, v_nxt} = r16[17:16];
                n_nxt = r16[15];
                z_nxt = (r16[15:0] == 16'h0000);
            end
            alu_branch_pkg::OP_SUB_EXIT: begin
                pgm_nxt = pop_word;
                stk_nxt = stack_top_pointer_r + alu_branch_pkg::STK_STEP;
            end
            alu_branch_pkg::OP_IRQ_EXIT: begin
                pgm_nxt = pop_word;
                {n_nxt, z_nxt, v_nxt, c_nxt} = pop_flags;
                stk_nxt = stack_top_pointer_r + alu_branch_pkg::STK_STEP_IRQ;
            end
            alu_branch_pkg::OP_JUMP_ABS:
                pgm_nxt = {instr_b1, instr_b2};
            alu_branch_pkg::OP_CALL_ABS, 8'b1110_1???: begin
                pgm_nxt = op[7] ? vec_target : {instr_b1, instr_b2};
                push_nxt = 1'b1;
                stk_nxt = stack_top_pointer_r - alu_branch_pkg::STK_STEP;
            end
            alu_branch_pkg::OP_PUSH_ACC, alu_branch_pkg::OP_PUSH_IDX: begin
                push_nxt = 1'b1;
                push_d = op[0] ? index_pointer_r : acc_r;
                stk_nxt = stack_top_pointer_r - alu_branch_pkg::STK_STEP;
            end
            alu_branch_pkg::OP_POP_ACC, alu_branch_pkg::OP_POP_IDX: begin
                if (op[0]) idx_nxt = pop_word;
                else acc_nxt = pop_word;
                stk_nxt = stack_top_pointer_r + alu_branch_pkg::STK_STEP;
            end
            8'h53, 8'h63, 8'h73: begin
                acc_nxt = lop(acc_r, tmp_r, op[5:4]);
                n_nxt = acc_nxt[15];
                z_nxt = (acc_nxt == 16'h0000);
                v_nxt = 1'b0;
            end
            8'h5?, 8'h6?, 8'h7?: begin
                if (|op[3:2] || op[3:0] == 4'h2) begin
                    x16 = lop({8'h00, acc_r[7:0]}, {8'h00, src8}, op[5:4]);
                    acc_nxt = {acc_r[15:8], x16[7:0]};
                    n_nxt = x16[7];
                    z_nxt = (x16[7:0] == 8'h00);
                    v_nxt = 1'b0;
                end
            end
            8'h1?, 8'h2?, 8'h3?: begin
                if (|op[3:2] || op[3:0] == 4'h2) begin
                    if (op[3:0] == 4'h2 && op[4]) begin
                        x8 = tmp_r[7:0];
                        y8 = acc_r[7:0];
                    end
                    r8 = add8(x8, y8, op[5] & carry_r, op[4]);
                    if (op[5]) acc_nxt = {acc_r[15:8], r8[7:0]};
                    {c_nxt, v_nxt} = r8[9:8];
                    n_nxt = r8[7];
                    z_nxt = (r8[7:0] == 8'h00);
                end
            end
            8'h95, 8'h96, 8'h97, 8'b1001_1???: begin
                x8 = op[3] ? bank_r[ri] : opnd_byte;
                r8 = add8(x8, instr_b1, 1'b0, 1'b1);
                {c_nxt, v_nxt} = r8[9:8];
                n_nxt = r8[7];
                z_nxt = (r8[7:0] == 8'h00);
            end
            alu_branch_pkg::OP_FIX_ADD, alu_branch_pkg::OP_FIX_SUB: begin
                // Low nibble above nine picks the 06 step; carry or byte above 99 picks the 60 step
                f_sel = carry_r || (acc_r[7:0] > 8'h99);
                y8 = {f_sel ? 4'h6 : 4'h0,
                      (acc_r[3:0] > 4'h9) ? 4'h6 : 4'h0};
                r8 = add8(acc_r[7:0], y8, 1'b0, op[4]);
                acc_nxt = {acc_r[15:8], r8[7:0]};
                c_nxt = f_sel;
                v_nxt = r8[8];
                n_nxt = r8[7];
                z_nxt = (r8[7:0] == 8'h00);
            end
            alu_branch_pkg::OP_IRQ_OFF, alu_branch_pkg::OP_IRQ_ON:
                ie_nxt = op[4];
            alu_branch_pkg::OP_CARRY_OFF, alu_branch_pkg::OP_CARRY_ON:
                c_nxt = op[4];
            alu_branch_pkg::OP_UP_ACC, alu_branch_pkg::OP_DN_ACC: begin
                acc_nxt = op[4] ? acc_r - 16'h0001
                                : acc_r + 16'h0001;
                n_nxt = acc_nxt[15];
                z_nxt = (acc_nxt == 16'h0000);
            end
            alu_branch_pkg::OP_UP_STK, alu_branch_pkg::OP_DN_STK:
                stk_nxt = op[4] ? stack_top_pointer_r - 16'h0001
                                : stack_top_pointer_r + 16'h0001;
            alu_branch_pkg::OP_UP_IDX, alu_branch_pkg::OP_DN_IDX:
                idx_nxt = op[4] ? index_pointer_r - 16'h0001
                                : index_pointer_r + 16'h0001;
            alu_branch_pkg::OP_UP_XPT, alu_branch_pkg::OP_DN_XPT:
                xpt_nxt = op[4] ? extra_pointer_r - 16'h0001
                                : extra_pointer_r + 16'h0001;
            8'b1100_1???, 8'b1101_1???: begin
                r8 = add8(bank_r[ri], 8'h01, 1'b0, op[4]);
                bank_we = 1'b1;
                bank_nxt = r8[7:0];
                v_nxt = r8[8];
                n_nxt = r8[7];
                z_nxt = (r8[7:0] == 8'h00);
            end
            alu_branch_pkg::OP_JUMP_ACC: pgm_nxt = acc_r;
            alu_branch_pkg::OP_SWAP_PGM: begin
                pgm_nxt = acc_r;
                acc_nxt = pcn;
            end
            8'hb?: begin
                z_nxt = ~bit_v;
                if (bit_v == op[3])
                    pgm_nxt = pcn + {{8{instr_b2[7]}}, instr_b2};
            end
            8'b1111_1???: begin
                // Flag pick: carry, negative, zero, overflow or negative
                case (op[2:1])
                    2'b00: f_sel = carry_r;
                    2'b01: f_sel = neg_r;
                    2'b10: f_sel = zero_r;
                    default: f_sel = ovf_r | neg_r;
                endcase
                if (f_sel == op[0])
                    pgm_nxt = pcn + {{8{instr_b1[7]}}, instr_b1};
            end
            default: ; // Other opcodes only advance the program counter
        endcase
    end

    // Busy count: one cycle per documented execution cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 5'h00;
            instr_ready_r <= 1'b1;
        end else if (ce) begin
            if (take) begin
                wait_r <= cyc_of(op) - 5'h01;
                instr_ready_r <= (cyc_of(op) == 5'h01);
            end else if (wait_r != 5'h00) begin
                wait_r <= wait_r - 5'h01;
                instr_ready_r <= (wait_r == 5'h01);
            end
        end
    end

    // Register and flag update when an opcode is taken
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_counter_r <= alu_branch_pkg::WORD_RESET;
            acc_r <= alu_branch_pkg::WORD_RESET;
            tmp_r <= alu_branch_pkg::WORD_RESET;
            index_pointer_r <= alu_branch_pkg::WORD_RESET;
            extra_pointer_r <= alu_branch_pkg::WORD_RESET;
            stack_top_pointer_r <= alu_branch_pkg::WORD_RESET;
            {neg_r, zero_r, ovf_r, carry_r, irq_en_r} <= 5'h00;
        end else if (take) begin
            program_counter_r <= pgm_nxt;
            acc_r <= acc_nxt;
            tmp_r <= tmp_nxt;
            index_pointer_r <= idx_nxt;
            extra_pointer_r <= xpt_nxt;
            stack_top_pointer_r <= stk_nxt;
            {neg_r, zero_r, ovf_r, carry_r} <=
                {n_nxt, z_nxt, v_nxt, c_nxt};
            irq_en_r <= ie_nxt;
        end
    end

    // Stack write request, one cycle per push
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            push_valid_r <= 1'b0;
            push_data_r <= alu_branch_pkg::WORD_RESET;
        end else if (ce) begin
            push_valid_r <= take && push_nxt;
            if (take && push_nxt) push_data_r <= push_d;
        end
    end

    // Bank registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) bank_r[i] <= 8'h00;
        end else if (take && bank_we) begin
            bank_r[ri] <= bank_nxt;
        end
    end
endmodule // cpu_alu_branch_decoder

// *** sim/alu_branch_assertions.sv ***
// Concurrent checks on the execute unit ports.
// Assumes a bind from the bench top; one clock, async active-low reset.
`timescale 1ns/100ps
module alu_branch_assertions (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Instruction
    input wire logic instr_valid,
    input wire logic [7:0] instr_op,
    input wire logic [7:0] instr_b1,
    input wire logic [7:0] instr_b2,
    // Results
    input wire logic instr_ready_r,
    input wire logic push_valid_r,
    input wire logic [15:0] push_data_r,
    input wire logic [15:0] program_counter_r,
    input wire logic [15:0] acc_r,
    input wire logic [15:0] stack_top_pointer_r,
    input wire logic neg_r,
    input wire logic zero_r,
    input wire logic ovf_r,
    input wire logic carry_r
);
    logic go;
    logic [3:0] flg;
    // Take strobe and flag vector
    assign go = ce && instr_valid && instr_ready_r;
    assign flg = {neg_r, zero_r, ovf_r, carry_r};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Busy spans and call steps
    sequence s_busy2;
        !instr_ready_r [*2] ##1 instr_ready_r;
    endsequence
    sequence s_busy3;
        !instr_ready_r [*3] ##1 instr_ready_r;
    endsequence
    sequence s_call;
        push_valid_r && program_counter_r == {$past(instr_b1),
        $past(instr_b2)} && push_data_r == $past(program_counter_r) + 16'h3
        && stack_top_pointer_r == $past(stack_top_pointer_r) - 16'h2
        ##1 !push_valid_r;
    endsequence
    AST_WADD_BUSY: assert property (
        go && instr_op == 8'h23 |=> s_busy2)
        else $error("word add busy span wrong");
    AST_MUL_SPAN: assert property (
        go && instr_op == 8'h01 |=> flg == $past(flg)
        ##17 !instr_ready_r ##1 instr_ready_r)
        else $error("multiply span or flags wrong");
    AST_DIV_SPAN: assert property (
        go && instr_op == 8'h11 |=> flg == $past(flg)
        ##19 !instr_ready_r ##1 instr_ready_r)
        else $error("divide span or flags wrong");
    AST_BANK_BUMP: assert property (
        go && (instr_op[7:3] == 5'h19 || instr_op[7:3] == 5'h1b)
        |=> carry_r == $past(carry_r) ##0 s_busy3)
        else $error("bank bump carry or span wrong");
    AST_PTR_FLAGS: assert property (
        go && instr_op inside {8'hc1, 8'hc2, 8'hc3, 8'hd1, 8'hd2, 8'hd3}
        |=> flg == $past(flg))
        else $error("pointer bump changed a flag");
    AST_ACC_BUMP: assert property (
        go && (instr_op == 8'hc0 || instr_op == 8'hd0) |=>
        {ovf_r, carry_r} == $past({ovf_r, carry_r}) &&
        zero_r == (acc_r == 16'h0000) && neg_r == acc_r[15])
        else $error("accumulator bump flags wrong");
    AST_WORD_LOGIC: assert property (
        go && instr_op inside {8'h53, 8'h63, 8'h73} |=> !ovf_r &&
        carry_r == $past(carry_r) && neg_r == acc_r[15])
        else $error("word logic flags wrong");
    AST_CARRY_OPS: assert property (
        go && (instr_op == 8'h81 || instr_op == 8'h91) |=> instr_ready_r
        && carry_r == $past(instr_op[4]) && flg[3:1] == $past(flg[3:1]))
        else $error("carry op wrong");
    AST_CALL_PUSH: assert property (
        go && instr_op == 8'h31 |=> s_call)
        else $error("call push wrong");
    AST_SWAP_PC: assert property (
        go && instr_op == 8'hf4 |=> program_counter_r == $past(acc_r)
        && acc_r == $past(program_counter_r) + 16'h0001)
        else $error("program counter swap wrong");
endmodule // alu_branch_assertions

// *** sim/alu_branch_memory_model.sv ***
// Memory beside the execute unit: stack words, direct bytes, vectors.
// Assumes pushes land at the already decremented stack pointer.
`timescale 1ns/100ps
module alu_branch_memory_model (
    // Clock and stack write
    input wire logic sys_clk,
    input wire logic push_valid_r,
    input wire logic [15:0] push_data_r,
    input wire logic [15:0] stack_top_pointer_r,
    // Instruction in flight
    input wire logic instr_valid,
    input wire logic [7:0] instr_op,
    input wire logic [7:0] instr_b1,
    // Read data
    output logic [7:0] opnd_byte,
    output logic [15:0] pop_word,
    output logic [3:0] pop_flags,
    output logic [15:0] vec_target
);
    logic [15:0] stack_mem [0:15];
    // Store each pushed word
    always @(posedge sys_clk) begin
        if (push_valid_r) stack_mem[stack_top_pointer_r[4:1]] <= push_data_r;
    end
    // Direct byte equals its address; idle shows the inverse
    assign opnd_byte = instr_valid ? instr_b1 : ~instr_b1;
    assign pop_word = stack_mem[stack_top_pointer_r[4:1]];
    assign pop_flags = pop_word[3:0];
    assign vec_target = {8'hf0, 2'b00, instr_op[2:0], 3'b000};
endmodule // alu_branch_memory_model

// *** sim/cpu_alu_branch_decoder_test.sv ***
// Self-checking bench for the execute unit with a memory model.
// Assumes the design package is compiled first; ce is held high.
`timescale 1ns/100ps
module cpu_alu_branch_decoder_test;
    logic sys_clk, rst_n, ce, instr_valid, instr_ready_r, push_valid_r;
    logic [7:0] instr_op, instr_b1, instr_b2, opnd_byte;
    logic [15:0] pop_word, vec_target, push_data_r, program_counter_r;
    logic [15:0] acc_r, tmp_r, index_pointer_r, extra_pointer_r;
    logic [15:0] stack_top_pointer_r, exp_pc, ret;
    logic [3:0] pop_flags;
    logic neg_r, zero_r, ovf_r, carry_r, irq_en_r;
    int failures, samples_checked, n, tick;
    cpu_alu_branch_decoder cpu_alu_branch_decoder_inst (.*);
    alu_branch_memory_model alu_branch_memory_model_inst (.*);
    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        $display("failures=%0d samples_checked=%0d", failures,
                 samples_checked);
        if (failures == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] a, e, input string m);
        samples_checked++;
        if (a !== e) begin
            failures++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // Offer one instruction, wait out its busy span, then compare
    task automatic exec(input logic [7:0] op, b1, b2, input int len, cy,
                        input logic [15:0] a, input logic [3:0] f);
        instr_op = op;
        instr_b1 = b1;
        instr_b2 = b2;
        instr_valid = 1'b1;
        @(negedge sys_clk);
        n = 1;
        while (instr_ready_r !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        exp_pc = exp_pc + 16'(len);
        chk16(program_counter_r, exp_pc, "pc");
        chk16(16'(n), 16'(cy), "cycle count");
        chk16(acc_r, a, "acc");
        chk16({12'h0, neg_r, zero_r, ovf_r, carry_r}, {12'h0, f}, "flags");
    endtask
    // Hang guard
    always @(posedge sys_clk) begin
        tick++;
        if (tick == 2000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        instr_valid = 1'b0;
        instr_op = 8'h00;
        instr_b1 = 8'h00;
        instr_b2 = 8'h00;
        exp_pc = 16'h0000;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        chk16({15'h0, instr_ready_r}, 16'h0001, "ready at reset");
        chk16(stack_top_pointer_r, 16'h0000, "sp at reset");
        exec(8'h91, 8'h00, 8'h00, 1, 1, 16'h0000, 4'h1);
        exec(8'h24, 8'h7f, 8'h00, 2, 2, 16'h0080, 4'ha);
        exec(8'hc0, 8'h00, 8'h00, 1, 3, 16'h0081, 4'h2);
        exec(8'h53, 8'h00, 8'h00, 1, 3, 16'h0081, 4'h0);
        exec(8'h91, 8'h00, 8'h00, 1, 1, 16'h0081, 4'h1);
        exec(8'h23, 8'h00, 8'h00, 1, 3, 16'h0082, 4'h0);
        exec(8'h34, 8'h83, 8'h00, 2, 2, 16'h00ff, 4'h9);
        exec(8'h33, 8'h00, 8'h00, 1, 3, 16'hff00, 4'h9);
        exec(8'h54, 8'hff, 8'h00, 2, 2, 16'hffff, 4'h9);
        exec(8'h81, 8'h00, 8'h00, 1, 1, 16'hffff, 4'h8);
        exec(8'h40, 8'h00, 8'h00, 1, 4, 16'hffff, 4'h8);
        exec(8'h51, 8'h00, 8'h00, 1, 4, 16'hffff, 4'h8);
        chk16(index_pointer_r, 16'hffff, "index pop");
        exec(8'hd1, 8'h00, 8'h00, 1, 3, 16'hffff, 4'h8);
        exec(8'hc3, 8'h00, 8'h00, 1, 3, 16'hffff, 4'h8);
        chk16(stack_top_pointer_r, 16'hffff, "sp bump");
        chk16(extra_pointer_r, 16'h0001, "extra bump");
        exec(8'h24, 8'h0b, 8'h00, 2, 2, 16'hff0a, 4'h1);
        exec(8'h84, 8'h00, 8'h00, 1, 2, 16'hff70, 4'h1);
        exec(8'h94, 8'h00, 8'h00, 1, 2, 16'hff10, 4'h1);
        exec(8'h81, 8'h00, 8'h00, 1, 1, 16'hff10, 4'h0);
        exec(8'hd0, 8'h00, 8'h00, 1, 3, 16'hff0f, 4'h8);
        exec(8'h01, 8'h00, 8'h00, 1, 19, 16'h0000, 4'h8);
        exec(8'hc1, 8'h00, 8'h00, 1, 3, 16'h0000, 4'h8);
        exec(8'h91, 8'h00, 8'h00, 1, 1, 16'h0000, 4'h9);
        exec(8'hcb, 8'h00, 8'h00, 1, 4, 16'h0000, 4'h1);
        exec(8'hdb, 8'h00, 8'h00, 1, 4, 16'h0000, 4'h5);
        exec(8'hdb, 8'h00, 8'h00, 1, 4, 16'h0000, 4'h9);
        exec(8'h02, 8'h00, 8'h00, 1, 2, 16'h0001, 4'h0);
        exec(8'h14, 8'h01, 8'h00, 2, 2, 16'h0001, 4'h4);
        exec(8'hfd, 8'h10, 8'h00, 18, 3, 16'h0001, 4'h4);
        exec(8'hfc, 8'h10, 8'h00, 2, 3, 16'h0001, 4'h4);
        exec(8'hff, 8'h20, 8'h00, 2, 3, 16'h0001, 4'h4);
        exec(8'hfe, 8'hf0, 8'h00, -14, 3, 16'h0001, 4'h4);
        exec(8'hb8, 8'h05, 8'h08, 11, 5, 16'h0001, 4'h0);
        exec(8'hb1, 8'h05, 8'h04, 7, 5, 16'h0001, 4'h4);
        ret = exp_pc + 16'h0003;
        exec(8'h31, 8'h12, 8'h34, int'(16'h1234 - exp_pc), 6, 16'h0001,
             4'h4);
        chk16(stack_top_pointer_r, 16'hfffe, "call sp");
        exec(8'h20, 8'h00, 8'h00, int'(ret - exp_pc), 4, 16'h0001,
             4'h4);
        exec(8'h11, 8'h00, 8'h00, 1, 21, 16'h0000, 4'h4);
        chk16(tmp_r, 16'h0000, "remainder");
        ret = exp_pc;
        exec(8'hf4, 8'h00, 8'h00, int'(16'h0000 - exp_pc), 3,
             ret + 16'h0001, 4'h4);
        exec(8'h90, 8'h00, 8'h00, 1, 1, ret + 16'h0001, 4'h4);
        chk16({15'h0, irq_en_r}, 16'h0001, "irq on");
        exec(8'h80, 8'h00, 8'h00, 1, 1, ret + 16'h0001, 4'h4);
        chk16({15'h0, irq_en_r}, 16'h0000, "irq off");
        instr_valid = 1'b0;
        repeat (3) @(negedge sys_clk);
        complete_run();
    end
endmodule // cpu_alu_branch_decoder_test
bind cpu_alu_branch_decoder alu_branch_assertions alu_branch_assertions_inst (.*);
